// ===== common/fci_pkg.sv
// Purpose: Constants and types for the flash command sequencer (host side)
// Assumes: Byte mode organisation, 100 MHz clock
// Notes: Behaviour
// Behaviour
// - Multi-write commands other than bypass program and bypass exit open with AA@AAA, 55@555
// - Program is unlock, A0@AAA, then target write
// - Success returns read mode; failure needs reset
// - Bypass program is A0 then target write
// - Bypass exit is 90 then 00
// - Chip erase is six writes ending 10@AAA
// - Block erase sixth write is 30@block
// - Address on strobe fall, data on rise
package fci_pkg;
  localparam logic [15:0] FCI_ADDR_UNLOCK1 = 16'h0aaa;
  localparam logic [15:0] FCI_ADDR_UNLOCK2 = 16'h0555;
  localparam logic [7:0] FCI_DATA_UNLOCK1 = 8'haa;
  localparam logic [7:0] FCI_DATA_UNLOCK2 = 8'h55;
  localparam logic [7:0] FCI_CMD_RESET = 8'hf0;
  localparam logic [7:0] FCI_CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] FCI_CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] FCI_CMD_BYPASS = 8'h20;
  localparam logic [7:0] FCI_CMD_BYPASS_EXIT = 8'h00;
  localparam logic [7:0] FCI_CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] FCI_CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] FCI_CMD_BLOCK_ERASE = 8'h30;
  localparam logic [7:0] FCI_CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] FCI_CMD_RESUME = 8'h30;
  localparam int FCI_BIT_POLL = 7;
  localparam int FCI_BIT_TOGGLE = 6;
  localparam int FCI_BIT_ERROR = 5;
  localparam int FCI_BIT_TIMEOUT = 3;
  localparam int FCI_CLK_NS = 10;
  localparam int FCI_SETUP_NS = 40;
  localparam int FCI_PULSE_NS = 40;
  localparam logic [3:0] FCI_SETUP_CYC = 4'((FCI_SETUP_NS + FCI_CLK_NS - 1) / FCI_CLK_NS);
  localparam logic [3:0] FCI_PULSE_CYC = 4'((FCI_PULSE_NS + FCI_CLK_NS - 1) / FCI_CLK_NS);
  localparam logic [3:0] FCI_STEP_RESET = 4'h0;

  typedef enum logic [3:0] {
    FCI_OP_RESET = 4'h0,
    FCI_OP_AUTOSEL = 4'h1,
    FCI_OP_PROGRAM = 4'h2,
    FCI_OP_BYPASS = 4'h3,
    FCI_OP_BYP_PROGRAM = 4'h4,
    FCI_OP_BYP_EXIT = 4'h5,
    FCI_OP_CHIP_ERASE = 4'h6,
    FCI_OP_BLOCK_ERASE = 4'h7,
    FCI_OP_SUSPEND = 4'h8,
    FCI_OP_RESUME = 4'h9,
    FCI_OP_READ = 4'ha,
    FCI_OP_BLOCK_ADD = 4'hb,
    FCI_OP_SHORT_RESET = 4'hc
  } fci_op_t;

  typedef struct packed {
    fci_op_t op;
    logic [15:0] addr;
    logic [7:0] data;
  } fci_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } fci_write_t;

  typedef enum logic [4:0] {
    FCI_ST_IDLE = 5'b00001,
    FCI_ST_SETUP = 5'b00010,
    FCI_ST_STROBE = 5'b00100,
    FCI_ST_HOLD = 5'b01000,
    FCI_ST_READ = 5'b10000
  } fci_state_t;
endpackage

// ===== hw/fci_host.sv
// Purpose: Host controller that issues flash commands over the parallel bus pins
// Assumes: Byte mode; user holds req stable until accepted
// Notes: One write or read per bus cycle; cycles chain into command sequences
`timescale 1ns/1ps
module fci_host
  import fci_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input fci_req_t req,
  output logic req_ready,
  output logic done,
  output logic [7:0] rd_data,
  output logic [15:0] flash_addr,
  output logic flash_addr_low,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_byte_n,
  input wire logic ready_busy_output,
  output logic busy,
  output logic poll_bit,
  output logic toggle_seen,
  output logic error_seen
);
  // Gives the address and data of one bus write of a command
  function automatic fci_write_t step_write(fci_op_t op, logic [2:0] idx,
                                            logic [15:0] a, logic [7:0] d);
    fci_write_t w;
    w = '{addr: FCI_ADDR_UNLOCK1, data: FCI_DATA_UNLOCK1};
    if (idx == 3'd1) begin
      w = '{addr: FCI_ADDR_UNLOCK2, data: FCI_DATA_UNLOCK2};
    end
    if (idx == 3'd2) begin
      unique case (op)
        FCI_OP_RESET: w = '{addr: a, data: FCI_CMD_RESET};
        FCI_OP_AUTOSEL: w = '{addr: FCI_ADDR_UNLOCK1, data: FCI_CMD_AUTOSEL};
        FCI_OP_PROGRAM: w = '{addr: FCI_ADDR_UNLOCK1, data: FCI_CMD_PROGRAM};
        FCI_OP_BYPASS: w = '{addr: FCI_ADDR_UNLOCK1, data: FCI_CMD_BYPASS};
        default: w = '{addr: FCI_ADDR_UNLOCK1, data: FCI_CMD_ERASE_SETUP};
      endcase
    end
    if (idx == 3'd3 && op == FCI_OP_PROGRAM) begin
      w = '{addr: a, data: d};
    end
    if (idx == 3'd4) begin
      w = '{addr: FCI_ADDR_UNLOCK2, data: FCI_DATA_UNLOCK2};
    end
    if (idx == 3'd5) begin
      w = '{addr: a, data: FCI_CMD_BLOCK_ERASE};
      if (op == FCI_OP_CHIP_ERASE) begin
        w = '{addr: FCI_ADDR_UNLOCK1, data: FCI_CMD_CHIP_ERASE};
      end
    end
    unique case (op)
      FCI_OP_BYP_PROGRAM: begin
        w = '{addr: a, data: d};
        if (idx == 3'd0) begin
          w = '{addr: a, data: FCI_CMD_PROGRAM};
        end
      end
      FCI_OP_BYP_EXIT: begin
        w = '{addr: a, data: FCI_CMD_BYPASS_EXIT};
        if (idx == 3'd0) begin
          w = '{addr: a, data: FCI_CMD_AUTOSEL};
        end
      end
      FCI_OP_SUSPEND: w = '{addr: a, data: FCI_CMD_SUSPEND};
      FCI_OP_RESUME: w = '{addr: a, data: FCI_CMD_RESUME};
      FCI_OP_SHORT_RESET: w = '{addr: a, data: FCI_CMD_RESET};
      FCI_OP_BLOCK_ADD: w = '{addr: a, data: FCI_CMD_BLOCK_ERASE};
      default: w = w;
    endcase
    return w;
  endfunction

  function automatic logic [2:0] op_len(fci_op_t op);
    unique case (op)
      FCI_OP_RESET, FCI_OP_AUTOSEL, FCI_OP_BYPASS: return 3'd3;
      FCI_OP_PROGRAM: return 3'd4;
      FCI_OP_CHIP_ERASE, FCI_OP_BLOCK_ERASE: return 3'd6;
      FCI_OP_BYP_PROGRAM, FCI_OP_BYP_EXIT: return 3'd2;
      default: return 3'd1;
    endcase
  endfunction

  fci_state_t state_reg, state_next;
  fci_req_t cur_reg, cur_next;
  logic [2:0] idx_reg, idx_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [15:0] addr_reg, addr_next;
  logic [7:0] dq_reg, dq_next;
  logic oe_reg, oe_next, ce_reg, ce_next, we_reg, we_next, rdoe_reg, rdoe_next;
  logic ready_reg, ready_next, done_reg, done_next;
  logic [7:0] rdat_reg, rdat_next;
  logic busy_reg, busy_next, poll_reg, poll_next, tog_reg, tog_next, err_reg, err_next;
  logic [7:0] din_s1, din_s2;
  logic rb_s1, rb_s2;
  fci_write_t w;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      din_s1 <= 8'h00;
      din_s2 <= 8'h00;
      rb_s1 <= 1'b1;
      rb_s2 <= 1'b1;
    end else begin
      din_s1 <= flash_dq_in;
      din_s2 <= din_s1;
      rb_s1 <= ready_busy_output;
      rb_s2 <= rb_s1;
    end
  end

  always_comb begin
    w = step_write(cur_reg.op, idx_reg, cur_reg.addr, cur_reg.data);
    state_next = state_reg;
    cur_next = cur_reg;
    idx_next = idx_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    dq_next = dq_reg;
    oe_next = oe_reg;
    ce_next = ce_reg;
    we_next = we_reg;
    rdoe_next = rdoe_reg;
    ready_next = ready_reg;
    done_next = 1'b0;
    rdat_next = rdat_reg;
    busy_next = ~rb_s2;
    poll_next = poll_reg;
    tog_next = tog_reg;
    err_next = err_reg;
    unique case (state_reg)
      FCI_ST_IDLE: begin
        if (req_valid && ready_reg) begin
          cur_next = req;
          idx_next = FCI_STEP_RESET[2:0];
          cnt_next = FCI_SETUP_CYC;
          ready_next = 1'b0;
          state_next = (req.op == FCI_OP_READ) ? FCI_ST_READ : FCI_ST_SETUP;
          addr_next = req.addr;
          ce_next = (req.op == FCI_OP_READ) ? 1'b0 : 1'b1;
          rdoe_next = (req.op == FCI_OP_READ) ? 1'b0 : 1'b1;
        end
      end
      FCI_ST_SETUP: begin
        // Address and data set up with output enable high before strobes fall
        addr_next = w.addr;
        dq_next = w.data;
        oe_next = 1'b1;
        rdoe_next = 1'b1;
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          ce_next = 1'b0;
          we_next = 1'b0;
          cnt_next = FCI_PULSE_CYC;
          state_next = FCI_ST_STROBE;
        end
      end
      FCI_ST_STROBE: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          we_next = 1'b1;
          ce_next = 1'b1;
          cnt_next = FCI_SETUP_CYC;
          state_next = FCI_ST_HOLD;
        end
      end
      FCI_ST_HOLD: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          oe_next = 1'b0;
          if (idx_reg + 3'd1 == op_len(cur_reg.op)) begin
            state_next = FCI_ST_IDLE;
            ready_next = 1'b1;
            done_next = 1'b1;
          end else begin
            idx_next = idx_reg + 3'd1;
            cnt_next = FCI_SETUP_CYC;
            state_next = FCI_ST_SETUP;
          end
        end
      end
      FCI_ST_READ: begin
        // Read pulse; status bits are decoded from each sampled word
        rdoe_next = 1'b0;
        ce_next = 1'b0;
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          rdat_next = din_s2;
          poll_next = din_s2[FCI_BIT_POLL];
          tog_next = din_s2[FCI_BIT_TOGGLE] ^ rdat_reg[FCI_BIT_TOGGLE];
          err_next = din_s2[FCI_BIT_ERROR];
          rdoe_next = 1'b1;
          ce_next = 1'b1;
          ready_next = 1'b1;
          done_next = 1'b1;
          state_next = FCI_ST_IDLE;
        end
      end
      default: state_next = FCI_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= FCI_ST_IDLE;
      cur_reg <= '0;
      idx_reg <= 3'd0;
      cnt_reg <= 4'h0;
      addr_reg <= 16'h0000;
      dq_reg <= 8'h00;
      oe_reg <= 1'b0;
      ce_reg <= 1'b1;
      we_reg <= 1'b1;
      rdoe_reg <= 1'b1;
      ready_reg <= 1'b1;
      done_reg <= 1'b0;
      rdat_reg <= 8'h00;
      busy_reg <= 1'b0;
      poll_reg <= 1'b0;
      tog_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      idx_reg <= idx_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      dq_reg <= dq_next;
      oe_reg <= oe_next;
      ce_reg <= ce_next;
      we_reg <= we_next;
      rdoe_reg <= rdoe_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      rdat_reg <= rdat_next;
      busy_reg <= busy_next;
      poll_reg <= poll_next;
      tog_reg <= tog_next;
      err_reg <= err_next;
    end
  end

  assign req_ready = ready_reg;
  assign done = done_reg;
  assign rd_data = rdat_reg;
  assign flash_addr = addr_reg;
  assign flash_addr_low = 1'b0;
  assign flash_dq_out = dq_reg;
  assign flash_dq_oe = oe_reg;
  assign flash_ce_n = ce_reg;
  assign flash_we_n = we_reg;
  assign flash_oe_n = rdoe_reg;
  assign flash_byte_n = 1'b0;
  assign busy = busy_reg;
  assign poll_bit = poll_reg;
  assign toggle_seen = tog_reg;
  assign error_seen = err_reg;

  sequence s_strobe_low;
    !flash_we_n && !flash_ce_n;
  endsequence
  property p_oe_high_in_write;
    @(posedge clk) disable iff (!reset_n) (!flash_we_n) |-> flash_oe_n;
  endproperty
  a_oe_high_in_write: assert property (p_oe_high_in_write) else $error("oe low in write");
  property p_strobe_width;
    @(posedge clk) disable iff (!reset_n) $fell(flash_we_n) |-> s_strobe_low [*4] ##1 flash_we_n;
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("bad strobe width");
  property p_data_stable;
    @(posedge clk) disable iff (!reset_n) !flash_we_n |-> $stable(flash_dq_out) && flash_dq_oe;
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved in strobe");
  property p_first_unlock;
    @(posedge clk) disable iff (!reset_n)
      ($fell(flash_we_n) && idx_reg == 3'd0 && cur_reg.op == FCI_OP_PROGRAM)
      |-> flash_addr == FCI_ADDR_UNLOCK1 && flash_dq_out == FCI_DATA_UNLOCK1;
  endproperty
  a_first_unlock: assert property (p_first_unlock) else $error("bad first unlock");
  property p_second_unlock;
    @(posedge clk) disable iff (!reset_n)
      ($fell(flash_we_n) && idx_reg == 3'd1 && cur_reg.op == FCI_OP_CHIP_ERASE)
      |-> flash_addr == FCI_ADDR_UNLOCK2 && flash_dq_out == FCI_DATA_UNLOCK2;
  endproperty
  a_second_unlock: assert property (p_second_unlock) else $error("bad second unlock");
  property p_prog_cmd;
    @(posedge clk) disable iff (!reset_n)
      ($fell(flash_we_n) && idx_reg == 3'd2 && cur_reg.op == FCI_OP_PROGRAM)
      |-> flash_dq_out == FCI_CMD_PROGRAM;
  endproperty
  a_prog_cmd: assert property (p_prog_cmd) else $error("bad program code");
  property p_chip_last;
    @(posedge clk) disable iff (!reset_n)
      ($fell(flash_we_n) && idx_reg == 3'd5 && cur_reg.op == FCI_OP_CHIP_ERASE)
      |-> flash_dq_out == FCI_CMD_CHIP_ERASE;
  endproperty
  a_chip_last: assert property (p_chip_last) else $error("bad chip erase code");
  property p_exit_second;
    @(posedge clk) disable iff (!reset_n)
      ($fell(flash_we_n) && idx_reg == 3'd1 && cur_reg.op == FCI_OP_BYP_EXIT)
      |-> flash_dq_out == FCI_CMD_BYPASS_EXIT;
  endproperty
  a_exit_second: assert property (p_exit_second) else $error("bad bypass exit");
endmodule

// ===== tb/fci_flash_model.sv
// Purpose: Behavioural flash device facing the host controller
// Assumes: Byte mode; busy time counted in clk cycles
// Notes: Block PROT_BLK is protected; program during erase suspend is not modelled
`timescale 1ns/1ps
module fci_flash_model
  import fci_pkg::*;
#(
  parameter logic [7:0] MAKER = 8'h5a, // Arbitrary value
  parameter logic [3:0] PROT_BLK = 4'hf,
  parameter int BUSY_CYC = 200,
  parameter int WAIT_CYC = 300
) (
  input wire logic clk,
  input wire logic [15:0] addr,
  input wire logic [7:0] din,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  output logic [7:0] dout,
  output logic rb
);
  localparam logic [10:0] U1 = FCI_ADDR_UNLOCK1[10:0];
  localparam logic [10:0] U2 = FCI_ADDR_UNLOCK2[10:0];
  logic [7:0] mem [256];
  logic [7:0] pd = 8'hff;
  logic [7:0] val;
  logic [7:0] last_q = 8'h00;
  logic [15:0] al = 16'h0000;
  logic [3:0] st = 4'h0;
  logic byp = 1'b0;
  logic asel = 1'b0;
  logic err = 1'b0;
  logic tog = 1'b0;
  int cnt = 0;
  logic sus = 1'b0;
  logic ers = 1'b0;
  logic [15:0] emask = 16'h0000;
  int wcnt = 0;
  wire stb_n = ce_n | we_n;
  wire stat = ((cnt > 0 || wcnt > 0) && !sus) || err;
  function automatic logic [7:0] ix(input logic [15:0] a);
    return {a[15:12], a[3:0]};
  endfunction
  initial for (int i = 0; i < 256; i++) mem[i] = (i[7:4] == PROT_BLK) ? 8'ha5 : 8'hff;
  always @* val = asel ? (addr[0] ? 8'h00 : MAKER) :
    (sus && emask[addr[15:12]]) ? 8'h80 :
    stat ? {~pd[7], tog, err, 5'h00} : mem[ix(addr)];
  // Released bus shows the inverse of the last word
  assign dout = (!ce_n && !oe_n) ? val : ~last_q;
  assign rb = (cnt == 0 && wcnt == 0) || sus;
  always @(posedge oe_n) begin
    last_q = val;
    if (stat) tog = ~tog;
  end
  always @(posedge clk) begin
    if (cnt > 0 && !sus) cnt <= cnt - 1;
    if (wcnt > 0 && !sus) wcnt <= wcnt - 1;
    if (ers && wcnt == 0 && cnt == 1 && !sus) begin
      ers <= 1'b0;
      emask <= 16'h0000;
    end
    // Block erase starts once the selection window runs out
    if (wcnt == 1 && !sus) begin
      for (int i = 0; i < 256; i++) if (emask[i[7:4]] && i[7:4] != PROT_BLK) mem[i] <= 8'hff;
      cnt <= BUSY_CYC;
    end
  end
  always @(negedge stb_n) al = addr;
  always @(posedge stb_n) begin
    logic [10:0] a;
    a = al[10:0];
    if (ers && !sus && din == 8'hb0) sus = 1'b1;
    else if (sus && din == 8'h30) sus = 1'b0;
    else if (wcnt > 0 && din == 8'h30) begin
      emask[al[15:12]] = 1'b1;
      wcnt = WAIT_CYC;
    end else if (cnt > 0 && !sus) begin
    end else if (err) begin
      if (din == 8'hf0) err = 1'b0;
      st = 4'h0;
    end else case (st)
      4'h0: begin
        asel = 1'b0;
        if (byp) st = din == 8'ha0 ? 4'h7 : din == 8'h90 ? 4'h8 : 4'h0;
        else if (din == 8'haa && a == U1) st = 4'h1;
      end
      4'h1, 4'h5: st = (din == 8'h55 && a == U2) ? st + 4'h1 : 4'h0;
      4'h2: begin
        st = 4'h0;
        if (din == 8'ha0 && a == U1) st = 4'h3;
        if (din == 8'h80 && a == U1) st = 4'h4;
        if (din == 8'h20 && a == U1) byp = 1'b1;
        if (din == 8'h90 && a == U1) asel = 1'b1;
      end
      4'h4: st = (din == 8'haa && a == U1) ? 4'h5 : 4'h0;
      4'h6: begin
        st = 4'h0;
        if (din == 8'h10 && a == U1) begin
          for (int i = 0; i < 256; i++) if (i[7:4] != PROT_BLK) mem[i] = 8'hff;
          pd = 8'hff;
          cnt = BUSY_CYC;
        end
        if (din == 8'h30) begin
          emask = 16'h0000;
          emask[al[15:12]] = 1'b1;
          ers = 1'b1;
          pd = 8'hff;
          wcnt = WAIT_CYC;
        end
      end
      4'h3, 4'h7: begin
        st = 4'h0;
        if (al[15:12] != PROT_BLK) begin
          err = |(din & ~mem[ix(al)]);
          mem[ix(al)] = mem[ix(al)] & din;
          pd = din;
          cnt = BUSY_CYC;
        end
      end
      4'h8: begin
        if (din == 8'h00) byp = 1'b0;
        st = 4'h0;
      end
      default: st = 4'h0;
    endcase
  end
endmodule

// ===== tb/fci_host_tb.sv
// Purpose: Self-checking bench for the flash command host
// Assumes: Behavioural flash model on the far side
// Notes: Device busy time shortened to a few hundred clocks
`timescale 1ns/1ps
module fci_host_tb;
  import fci_pkg::*;
  localparam logic [7:0] MAKER = 8'h5a;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0;
  fci_req_t req = '0;
  logic req_ready, done, busy, poll_bit, toggle_seen, error_seen, rb;
  logic flash_addr_low, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, flash_byte_n;
  logic [7:0] rd_data, flash_dq_out, dq_in;
  logic [15:0] flash_addr;
  int error_cnt = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  fci_host i_fci_host (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .done(done), .rd_data(rd_data), .flash_addr(flash_addr),
    .flash_addr_low(flash_addr_low), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(dq_in), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .flash_byte_n(flash_byte_n), .ready_busy_output(rb),
    .busy(busy), .poll_bit(poll_bit), .toggle_seen(toggle_seen), .error_seen(error_seen));
  fci_flash_model #(.MAKER(MAKER)) i_fci_flash_model (.clk(clk), .addr(flash_addr),
    .din(flash_dq_out), .ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n),
    .dout(dq_in), .rb(rb));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic issue(input fci_op_t op, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req <= '{op, a, d};
    @(posedge clk);
    req_valid <= 1'b0;
    while (done !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    check("done", 8'h01, {7'h00, done});
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    issue(FCI_OP_READ, a, 8'h00);
    check("rd_data", exp, rd_data);
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      issue(FCI_OP_READ, 16'h0000, 8'h00);
      n++;
    end
    check("ready", 8'h00, {7'h00, busy});
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    issue(FCI_OP_PROGRAM, 16'h0001, 8'h3c);
    check("busy", 8'h01, {7'h00, busy});
    issue(FCI_OP_READ, 16'h0001, 8'h00);
    check("status", 8'h80, rd_data & 8'ha0);
    issue(FCI_OP_PROGRAM, 16'h0003, 8'h00);
    issue(FCI_OP_READ, 16'h0001, 8'h00);
    check("toggle", 8'h01, {7'h00, toggle_seen});
    wait_ready();
    rd(16'h0001, 8'h3c);
    rd(16'h0003, 8'hff);
    check("byte_mode", 8'h00, {6'h00, flash_byte_n, flash_addr_low});
    issue(FCI_OP_PROGRAM, 16'hf001, 8'h00);
    rd(16'hf001, 8'ha5);
    issue(FCI_OP_PROGRAM, 16'h0001, 8'hc3);
    wait_ready();
    issue(FCI_OP_READ, 16'h0001, 8'h00);
    check("error", 8'h01, {7'h00, error_seen});
    issue(FCI_OP_READ, 16'h0002, 8'h00);
    check("err_hold", 8'h20, rd_data & 8'h20);
    issue(FCI_OP_SHORT_RESET, 16'h0000, 8'h00);
    rd(16'h0002, 8'hff);
    issue(FCI_OP_BYPASS, 16'h0000, 8'h00);
    issue(FCI_OP_BYP_PROGRAM, 16'h0005, 8'h5a);
    wait_ready();
    rd(16'h0005, 8'h5a);
    issue(FCI_OP_BYP_PROGRAM, 16'h0005, 8'ha5);
    wait_ready();
    issue(FCI_OP_SHORT_RESET, 16'h0000, 8'h00);
    issue(FCI_OP_BYP_PROGRAM, 16'h0006, 8'h0f);
    wait_ready();
    rd(16'h0006, 8'h0f);
    issue(FCI_OP_BYP_EXIT, 16'h0000, 8'h00);
    issue(FCI_OP_BYP_PROGRAM, 16'h0007, 8'h00);
    rd(16'h0007, 8'hff);
    issue(FCI_OP_AUTOSEL, 16'h0000, 8'h00);
    rd(16'h0000, MAKER);
    issue(FCI_OP_RESET, 16'h0000, 8'h00);
    rd(16'h0006, 8'h0f);
    issue(FCI_OP_CHIP_ERASE, 16'h0000, 8'h00);
    issue(FCI_OP_READ, 16'h0006, 8'h00);
    check("poll", 8'h00, {7'h00, poll_bit});
    issue(FCI_OP_SHORT_RESET, 16'h0000, 8'h00);
    check("busy", 8'h01, {7'h00, busy});
    wait_ready();
    rd(16'h0006, 8'hff);
    rd(16'hf001, 8'ha5);
    issue(FCI_OP_PROGRAM, 16'h0009, 8'h77);
    wait_ready();
    issue(FCI_OP_PROGRAM, 16'h1002, 8'h11);
    wait_ready();
    issue(FCI_OP_PROGRAM, 16'h2003, 8'h22);
    wait_ready();
    issue(FCI_OP_BLOCK_ERASE, 16'h1000, 8'h00);
    check("erase_wait", 8'h01, {7'h00, busy});
    // Second add lands only because the first add restarted the window
    repeat (200) @(posedge clk);
    issue(FCI_OP_BLOCK_ADD, 16'h3000, 8'h00);
    repeat (200) @(posedge clk);
    issue(FCI_OP_BLOCK_ADD, 16'h2000, 8'h00);
    issue(FCI_OP_SUSPEND, 16'h0000, 8'h00);
    rd(16'h0009, 8'h77);
    rd(16'h1002, 8'h80);
    check("suspend_rb", 8'h00, {7'h00, busy});
    issue(FCI_OP_RESUME, 16'h0000, 8'h00);
    issue(FCI_OP_READ, 16'h0009, 8'h00);
    check("resume", 8'h00, rd_data & 8'ha0);
    wait_ready();
    rd(16'h1002, 8'hff);
    rd(16'h2003, 8'hff);
    rd(16'h0009, 8'h77);
    wrap_up();
  end
  initial begin
    #400000;
    error_cnt++;
    wrap_up();
  end
endmodule
